/* File: rtl/card_cmd_pkg.sv */
`default_nettype none
package card_cmd_pkg;

  // Command control bytes
  localparam logic [7:0] CTRL_READ_MAIN   = 8'h30;
  localparam logic [7:0] CTRL_UPDATE_MAIN = 8'h38;
  localparam logic [7:0] CTRL_READ_PROT   = 8'h34;
  localparam logic [7:0] CTRL_WRITE_PROT  = 8'h3C;

  // Geometry
  localparam int MEM_ADDR_W = 8;
  localparam int MEM_DATA_W = 8;
  localparam int PROT_BITS  = 32;

  localparam logic [4:0]  CMD_LAST_BIT   = 5'h17;
  localparam logic [7:0]  PROT_LAST_ADDR = 8'h1F;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic [11:0] MEM_END_ADDR   = 12'h100;
  localparam logic [11:0] PROT_READ_BITS = 12'h020;
  localparam logic [2:0]  LAST_BIT_SEL   = 3'h7;
  localparam logic [31:0] PROT_RESET     = 32'h0000_0000;

  // Processing lengths in card clock pulses, nominal at 50 kHz
  localparam int NOM_ERASE_WRITE_US = 5000;
  localparam int NOM_SINGLE_OP_US   = 2500;
  localparam int NOM_CARD_CLK_KHZ   = 50;
  localparam logic [7:0] PULSES_ERASE_WRITE = 8'hFF;
  localparam logic [7:0] PULSES_SINGLE_OP   = 8'h7C;
  localparam logic [7:0] PULSES_LOCKED      = 8'h02;

  // Open-drain pin only ever pulls low
  localparam logic IO_DRIVE_LEVEL = 1'b0;

  typedef enum logic [5:0] {
    ST_IDLE      = 6'h01,
    ST_CMD       = 6'h02,
    ST_WAIT_STOP = 6'h04,
    ST_OUT_MAIN  = 6'h08,
    ST_OUT_PROT  = 6'h10,
    ST_PROC      = 6'h20
  } state_t;

  typedef struct packed {
    logic clk_rise;
    logic clk_fall;
    logic start;
    logic stop;
    logic io;
  } pin_evt_t;

  typedef struct packed {
    logic                  we;
    logic [MEM_ADDR_W-1:0] addr;
    logic [MEM_DATA_W-1:0] data;
  } mem_wr_t;

endpackage
`default_nettype wire

/* File: rtl/card_pin_events.sv */
`timescale 1ns/10ps
`default_nettype none
module card_pin_events (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 card_clk,
  input  wire logic                 card_io,
  output card_cmd_pkg::pin_evt_t    evt
);

  typedef struct packed {
    logic                   clk_prev;
    logic                   io_prev;
    card_cmd_pkg::pin_evt_t evt;
  } pin_state_t;

  pin_state_t s_reg;
  pin_state_t s_next;

  always_comb begin
    s_next              = s_reg;
    s_next.clk_prev     = card_clk;
    s_next.io_prev      = card_io;
    s_next.evt.io       = card_io;
    s_next.evt.clk_rise = card_clk & ~s_reg.clk_prev;
    s_next.evt.clk_fall = ~card_clk & s_reg.clk_prev;
    // Data edges only count while the clock stays high across both samples
    s_next.evt.start    = card_clk & s_reg.clk_prev & s_reg.io_prev & ~card_io; // [R19]
    s_next.evt.stop     = card_clk & s_reg.clk_prev & ~s_reg.io_prev & card_io; // [R19]
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign evt = s_reg.evt;

endmodule
`default_nettype wire

/* File: rtl/card_mem_array.sv */
`timescale 1ns/10ps
`default_nettype none
module card_mem_array #(
  parameter int ADDR_W = card_cmd_pkg::MEM_ADDR_W,
  parameter int DATA_W = card_cmd_pkg::MEM_DATA_W
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic [ADDR_W-1:0]    rd_addr,
  output logic      [DATA_W-1:0]    rd_data,
  input  wire card_cmd_pkg::mem_wr_t wr
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Reset to the erased pattern so simulation starts from a known image
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem[i] <= card_cmd_pkg::ERASED_BYTE;
      end
    end else if (wr.we) begin
      mem[wr.addr] <= wr.data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule
`default_nettype wire

/* File: rtl/card_memory_command_exec.sv */
// Function
// [R01] Main read streams bytes LSB first from address N to the last byte.
// [R02] Main read takes (256-N)*8+1 pulses; last pulse releases the line.
// [R03] Reader keeps clocking until all bits and the release pulse are done.
// [R04] Main memory reads are always allowed, whatever the protection state.
// [R05] Control 0x30 is main read; second byte start address, third ignored.
// [R06] Protection read gives 32 bits in 32 pulses, one more releases.
// [R07] Protection memory always readable; a set bit locks same-address byte.
// [R08] Control 0x34 is protection read; address and data bytes ignored.
// [R09] Update needing erase and write lasts 255 pulses.
// [R10] Update needing only erase or only write lasts 124 pulses.
// [R11] Reader converts pulse counts to time assuming a 50 kHz clock.
// [R12] Control 0x38 updates the addressed byte with the third byte.
// [R13] Locked target skips programming and releases after processing pulse 2.
// [R14] Protection write sets the bit when supplied byte equals stored byte.
// [R15] Protection write with differing byte leaves the bit unchanged.
// [R16] Protection write uses the same pulse counts as an update; code always runs 124 pulses.
// [R17] Protection write accepted only for addresses 0x00 to 0x1F.
// [R18] Only addresses 0 to 31 have protection bits; others never lock.
// [R19] Command: start, three bytes LSB first, one extra clock, stop.
// [R20] Processing pulls the line low from first falling edge until done.
// [R21] After last read bit one more clock releases; ready for new command.
// [R22] Erase skipped without 0-to-1 change, write skipped without 1-to-0.
// [R23] After a sequence, line released and clocks ignored until next start.
`timescale 1ns/10ps
`default_nettype none
module card_memory_command_exec #(
  parameter int ADDR_W = card_cmd_pkg::MEM_ADDR_W,
  parameter int DATA_W = card_cmd_pkg::MEM_DATA_W,
  parameter int PROT_W = card_cmd_pkg::PROT_BITS
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic card_clk,
  input  wire logic card_rst,
  input  wire logic card_io_in,
  output logic      card_io_out,
  output logic      card_io_oe
);

  typedef struct packed {
    card_cmd_pkg::state_t st;
    logic [4:0]           bit_cnt;
    logic [23:0]          cmd;
    logic [ADDR_W-1:0]    addr;
    logic [2:0]           bit_sel;
    logic [11:0]          remain;
    logic [7:0]           pulses;
    logic [7:0]           total;
    logic                 prot_cmd;
    logic                 commit;
    logic [PROT_W-1:0]    prot;
    logic                 io_oe;
    logic                 io_out;
    card_cmd_pkg::mem_wr_t wr;
  } core_t;

  core_t s_reg;
  core_t s_next;

  card_cmd_pkg::pin_evt_t evt;
  logic [DATA_W-1:0]      rd_data;

  card_pin_events u_pins (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .card_clk (card_clk),
    .card_io  (card_io_in),
    .evt      (evt)
  );

  card_mem_array #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_mem (
    .ref_clk (ref_clk),
    .rst     (rst),
    .rd_addr (s_reg.addr),
    .rd_data (rd_data),
    .wr      (s_reg.wr)
  );

  // Bits still to stream for a main read from start address n
  function automatic logic [11:0] main_read_bits(input logic [7:0] n);
    logic [11:0] span;
    span = card_cmd_pkg::MEM_END_ADDR - {4'h0, n};
    return {span[8:0], 3'h0}; // [R02]
  endfunction

  function automatic logic needs_erase(input logic [7:0] old_b, input logic [7:0] new_b);
    return |(~old_b & new_b); // [R22]
  endfunction

  function automatic logic needs_write(input logic [7:0] old_b, input logic [7:0] new_b);
    return |(old_b & ~new_b); // [R22]
  endfunction

  // Only the low 32 addresses carry a protection bit
  function automatic logic is_locked(input logic [7:0] a, input logic [PROT_W-1:0] p);
    return (a <= card_cmd_pkg::PROT_LAST_ADDR) && p[a[4:0]]; // [R18]
  endfunction

  always_comb begin
    s_next        = s_reg;
    s_next.wr.we  = 1'b0;
    s_next.io_out = card_cmd_pkg::IO_DRIVE_LEVEL;
    if (card_rst) begin
      // Break: abort whatever runs and let go of the line
      s_next.st    = card_cmd_pkg::ST_IDLE;
      s_next.io_oe = 1'b0;
    end else begin
      case (s_reg.st)
        card_cmd_pkg::ST_IDLE: begin
          s_next.io_oe = 1'b0; // [R23]
          if (evt.start) begin
            s_next.st      = card_cmd_pkg::ST_CMD;
            s_next.bit_cnt = '0;
          end
        end

        card_cmd_pkg::ST_CMD: begin
          if (evt.start) begin
            s_next.bit_cnt = '0;
          end else if (evt.stop) begin
            // Short frame is dropped
            s_next.st = card_cmd_pkg::ST_IDLE;
          end else if (evt.clk_rise) begin
            s_next.cmd     = {evt.io, s_reg.cmd[23:1]}; // [R19]
            s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
            if (s_reg.bit_cnt == card_cmd_pkg::CMD_LAST_BIT) begin
              s_next.st = card_cmd_pkg::ST_WAIT_STOP;
            end
          end
        end

        card_cmd_pkg::ST_WAIT_STOP: begin
          // The extra clock pulse passes here unnoticed
          if (evt.start) begin
            s_next.st      = card_cmd_pkg::ST_CMD;
            s_next.bit_cnt = '0;
          end else if (evt.stop) begin
            s_next.addr    = s_reg.cmd[15:8];
            s_next.bit_sel = '0;
            s_next.pulses  = '0;
            s_next.total   = '0;
            s_next.commit  = 1'b0;
            if (s_reg.cmd[7:0] == card_cmd_pkg::CTRL_READ_MAIN) begin
              // No protection or verification check on this path
              s_next.st     = card_cmd_pkg::ST_OUT_MAIN; // [R05] [R04]
              s_next.remain = main_read_bits(s_reg.cmd[15:8]); // [R02]
            end else if (s_reg.cmd[7:0] == card_cmd_pkg::CTRL_READ_PROT) begin
              s_next.st     = card_cmd_pkg::ST_OUT_PROT; // [R08] [R07]
              s_next.addr   = '0; // [R08]
              s_next.remain = card_cmd_pkg::PROT_READ_BITS; // [R06]
            end else if (s_reg.cmd[7:0] == card_cmd_pkg::CTRL_UPDATE_MAIN) begin
              s_next.st       = card_cmd_pkg::ST_PROC; // [R12]
              s_next.prot_cmd = 1'b0;
            end else if (s_reg.cmd[7:0] == card_cmd_pkg::CTRL_WRITE_PROT) begin
              if (s_reg.cmd[15:8] <= card_cmd_pkg::PROT_LAST_ADDR) begin
                s_next.st       = card_cmd_pkg::ST_PROC; // [R17]
                s_next.prot_cmd = 1'b1;
              end else begin
                s_next.st = card_cmd_pkg::ST_IDLE; // [R17] [R18]
              end
            end else begin
              s_next.st = card_cmd_pkg::ST_IDLE;
            end
          end
        end

        card_cmd_pkg::ST_OUT_MAIN: begin
          // Start and stop are discarded while streaming
          if (evt.clk_fall) begin
            if (s_reg.remain == '0) begin
              s_next.io_oe = 1'b0; // [R21] [R02]
              s_next.st    = card_cmd_pkg::ST_IDLE; // [R23]
            end else begin
              // Pulling low sends a zero; a one is the pull-up
              s_next.io_oe   = ~rd_data[s_reg.bit_sel]; // [R01]
              s_next.bit_sel = s_reg.bit_sel + 3'h1;
              s_next.remain  = s_reg.remain - 12'h001;
              if (s_reg.bit_sel == card_cmd_pkg::LAST_BIT_SEL) begin
                s_next.addr = s_reg.addr + 8'h01; // [R01]
              end
            end
          end
        end

        card_cmd_pkg::ST_OUT_PROT: begin
          if (evt.clk_fall) begin
            if (s_reg.remain == '0) begin
              s_next.io_oe = 1'b0; // [R06] [R21]
              s_next.st    = card_cmd_pkg::ST_IDLE; // [R23]
            end else begin
              // Read back as zero once written
              s_next.io_oe  = s_reg.prot[s_reg.addr[4:0]]; // [R06] [R07]
              s_next.addr   = s_reg.addr + 8'h01;
              s_next.remain = s_reg.remain - 12'h001;
            end
          end
        end

        card_cmd_pkg::ST_PROC: begin
          if (evt.clk_fall) begin
            s_next.pulses = s_reg.pulses + 8'h01;
            if (s_reg.pulses == '0) begin
              // Old byte is valid now, address settled at decode
              s_next.io_oe = 1'b1; // [R20]
              if (s_reg.prot_cmd) begin
                s_next.total  = card_cmd_pkg::PULSES_SINGLE_OP; // [R16]
                s_next.commit = (rd_data == s_reg.cmd[23:16]); // [R14] [R15]
              end else if (is_locked(s_reg.addr, s_reg.prot)) begin
                s_next.total  = card_cmd_pkg::PULSES_LOCKED; // [R13] [R07]
                s_next.commit = 1'b0; // [R13]
              end else if (needs_erase(rd_data, s_reg.cmd[23:16]) &&
                           needs_write(rd_data, s_reg.cmd[23:16])) begin
                s_next.total  = card_cmd_pkg::PULSES_ERASE_WRITE; // [R09]
                s_next.commit = 1'b1;
              end else begin
                // Nothing to change still runs the short sequence
                s_next.total  = card_cmd_pkg::PULSES_SINGLE_OP; // [R10] [R22]
                s_next.commit = needs_erase(rd_data, s_reg.cmd[23:16]) |
                                needs_write(rd_data, s_reg.cmd[23:16]); // [R22]
              end
            end else if (s_next.pulses == s_reg.total) begin
              s_next.io_oe = 1'b0; // [R20]
              s_next.st    = card_cmd_pkg::ST_IDLE; // [R23]
              if (s_reg.commit && s_reg.prot_cmd) begin
                // One-way: no command clears a protection bit, only rst does
                s_next.prot[s_reg.addr[4:0]] = 1'b1; // [R14]
              end else if (s_reg.commit) begin
                s_next.wr.we   = 1'b1; // [R12]
                s_next.wr.addr = s_reg.addr;
                s_next.wr.data = s_reg.cmd[23:16];
              end
            end
          end
        end

        default: begin
          s_next.st    = card_cmd_pkg::ST_IDLE;
          s_next.io_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.st       <= card_cmd_pkg::ST_IDLE;
      s_reg.prot     <= card_cmd_pkg::PROT_RESET;
      s_reg.io_out   <= card_cmd_pkg::IO_DRIVE_LEVEL;
    end else begin
      s_reg <= s_next;
    end
  end

  assign card_io_out = s_reg.io_out;
  assign card_io_oe  = s_reg.io_oe;

endmodule
`default_nettype wire

/* File: tb/card_exec_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module card_exec_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic card_clk,
  input wire logic card_rst,
  input wire logic card_io_in,
  input wire logic card_io_out,
  input wire logic card_io_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_out_low;
    card_io_out == 1'h0;
  endproperty
  a_out_low: assert property (p_out_low) else $error("io out high");
  property p_break;
    card_rst |=> !card_io_oe;
  endproperty
  a_break: assert property (p_break) else $error("break kept line");
  property p_rise_sync;
    $rose(card_io_oe) |-> $past(card_clk, 3) && !$past(card_clk, 2);
  endproperty
  a_rise_sync: assert property (p_rise_sync) else $error("pull not on fall");
  // Break drops the line off-beat, so it is excluded
  property p_fall_sync;
    disable iff (rst || card_rst)
    $fell(card_io_oe) |-> $past(card_clk, 3) && !$past(card_clk, 2);
  endproperty
  a_fall_sync: assert property (p_fall_sync) else $error("release not on fall");
  property p_rise_quiet;
    disable iff (rst || card_rst)
    $rose(card_clk) |-> $stable(card_io_oe) [*4];
  endproperty
  a_rise_quiet: assert property (p_rise_quiet) else $error("line moved on rise");
  property p_stop_quiet;
    card_clk && $rose(card_io_in) |=> !card_io_oe [*4];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("pull after stop");
  property p_start_quiet;
    card_clk && $fell(card_io_in) |=> !card_io_oe [*4];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("pull after start");
  property p_settle;
    disable iff (rst || card_rst)
    $changed(card_io_oe) |=> $stable(card_io_oe) [*3];
  endproperty
  a_settle: assert property (p_settle) else $error("line toggled twice");
endmodule
bind card_memory_command_exec card_exec_sva u_sva (.ref_clk(ref_clk), .rst(rst),
  .card_clk(card_clk), .card_rst(card_rst), .card_io_in(card_io_in),
  .card_io_out(card_io_out), .card_io_oe(card_io_oe));
`default_nettype wire

/* File: tb/card_reader_host.sv */
`timescale 1ns/10ps
`default_nettype none
module card_reader_host (
  input  wire logic ref_clk,
  input  wire logic card_io_oe,
  output var logic  card_clk,
  output var logic  card_rst,
  output wire logic card_io_in
);
  logic host_io;
  // Pull-up: low if either side pulls
  assign card_io_in = host_io & ~card_io_oe;
  initial begin
    card_clk = 1'h0;
    card_rst = 1'h0;
    host_io  = 1'h1;
  end
  // Four samples per level, clock still outside frames
  task automatic drive(input logic c, input logic d);
    @(posedge ref_clk);
    #1;
    card_clk = c;
    host_io  = d;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic send_cmd(input logic [23:0] f);
    drive(1'h1, 1'h1);
    drive(1'h1, 1'h0);
    for (int i = 0; i < 24; i++) begin
      drive(1'h0, f[i]);
      drive(1'h1, f[i]);
    end
    drive(1'h0, 1'h0);
    drive(1'h1, 1'h0);
    drive(1'h1, 1'h1);
  endtask
  // Counts are pulses, the rate is ours
  task automatic pulse(output logic b);
    drive(1'h0, 1'h1);
    #1;
    b = card_io_in;
    drive(1'h1, 1'h1);
  endtask
  task automatic brk();
    drive(1'h0, 1'h1);
    #1;
    card_rst = 1'h1;
    repeat (4) @(posedge ref_clk);
    #1;
    card_rst = 1'h0;
  endtask
endmodule
`default_nettype wire

/* File: tb/card_memory_command_exec_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module card_memory_command_exec_tb;
  logic        ref_clk = 1'h0;
  logic        rst = 1'h1;
  wire         card_clk;
  wire         card_rst;
  wire         card_io_in;
  wire         card_io_out;
  wire         card_io_oe;
  logic [7:0]  mem_m [256];
  logic [31:0] prot_m;
  int          bad_count = 0;
  int          checked = 0;
  int          cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  card_memory_command_exec dut (.ref_clk(ref_clk), .rst(rst), .card_clk(card_clk),
    .card_rst(card_rst), .card_io_in(card_io_in), .card_io_out(card_io_out),
    .card_io_oe(card_io_oe));
  card_reader_host host (.ref_clk(ref_clk), .card_io_oe(card_io_oe), .card_clk(card_clk),
    .card_rst(card_rst), .card_io_in(card_io_in));
  task automatic finish_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      bad_count++;
      $display("[ERR] run length expected end seen hang");
      finish_test();
    end
  end
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  function automatic logic [31:0] upd_len(input logic [7:0] a, input logic [7:0] d);
    if (a <= 8'h1F && prot_m[a[4:0]]) return 32'h2;
    return (|(~mem_m[a] & d) && |(mem_m[a] & ~d)) ? 32'hFF : 32'h7C;
  endfunction
  // Pulses until the line is let go; a refused command gives one
  task automatic proc(input logic [23:0] f, input logic [31:0] e);
    logic        b;
    logic [31:0] n;
    host.send_cmd(f);
    n = 32'h0;
    b = 1'h0;
    while (b !== 1'h1 && n < 32'h12C) begin
      host.pulse(b);
      n++;
    end
    check("pulses", e, n);
  endtask
  task automatic update(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] e;
    e = upd_len(a, d);
    proc({d, a, card_cmd_pkg::CTRL_UPDATE_MAIN}, e);
    if (e != 32'h2) mem_m[a] = d;
  endtask
  task automatic wprot(input logic [7:0] a, input logic [7:0] d);
    proc({d, a, card_cmd_pkg::CTRL_WRITE_PROT}, a <= 8'h1F ? 32'h7C : 32'h1);
    if (a <= 8'h1F && mem_m[a] == d) prot_m[a[4:0]] = 1'h1;
  endtask
  task automatic rd_main(input logic [7:0] n, input logic [7:0] d);
    logic [7:0] v;
    logic       b;
    host.send_cmd({d, n, card_cmd_pkg::CTRL_READ_MAIN});
    for (int a = n; a < 256; a++) begin
      for (int i = 0; i < 8; i++) begin
        host.pulse(b);
        v[i] = b;
      end
      check("main byte", 32'(mem_m[a]), 32'(v));
    end
    host.pulse(b);
    check("main release", 32'h1, 32'(b));
    host.pulse(b);
    check("idle clock", 32'h1, 32'(b));
  endtask
  task automatic rd_prot(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] v;
    logic        b;
    host.send_cmd({d, a, card_cmd_pkg::CTRL_READ_PROT});
    for (int i = 0; i < 32; i++) begin
      host.pulse(b);
      v[i] = ~b;
    end
    check("prot bits", prot_m, v);
    host.pulse(b);
    check("prot release", 32'h1, 32'(b));
  endtask
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    logic       b;
    logic [7:0] seq [5];
    seq = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'hA5};
    void'($urandom(86422));
    for (int i = 0; i < 256; i++) mem_m[i] = 8'hFF;
    prot_m = 32'h0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    repeat (2) @(posedge ref_clk);
    check("idle line", 32'h1, 32'(card_io_in));
    check("io out", 32'h0, 32'(card_io_out));
    rd_main(8'hFE, 8'($urandom));
    rd_main(8'hFF, 8'($urandom));
    rd_prot(8'($urandom), 8'($urandom));
    $display("test reads done");
    // Write only, erase only, write only, both, no change
    for (int i = 0; i < 5; i++) update(8'h1F, seq[i]);
    update(8'hFF, 8'h00);
    $display("test updates done");
    wprot(8'h1F, 8'h5A);
    wprot(8'h1F, 8'hA5);
    update(8'h1F, 8'h00);
    wprot(8'h20, mem_m[8'h20]);
    update(8'h20, 8'h3C);
    proc({8'h00, 8'h00, 8'h31}, 32'h1);
    rd_prot(8'h1F, 8'h00);
    $display("test protect done");
    // Same data, so memory is defined whatever the abort leaves
    host.send_cmd({mem_m[8'h10], 8'h10, card_cmd_pkg::CTRL_UPDATE_MAIN});
    repeat (3) host.pulse(b);
    host.brk();
    host.pulse(b);
    check("after break", 32'h1, 32'(b));
    $display("test break done");
    repeat (10) begin
      a = 8'($urandom);
      d = 8'($urandom);
      case ($urandom % 4)
        0: update(a, d);
        1: wprot(a, a[0] ? mem_m[a] : d);
        2: rd_prot(a, d);
        default: rd_main({3'h7, a[4:0]}, d);
      endcase
    end
    $display("test random done");
    rd_main(8'h00, 8'($urandom));
    $display("test full read done");
    finish_test();
  end
endmodule
`default_nettype wire
